// ---- common/haptic_ctrl_pkg.sv ----
// Package of offsets, field layouts, reset values and timing constants for the loop control register.
package haptic_ctrl_pkg;

  // Register bus geometry.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Byte offset of the input and loop timing control register.
  localparam logic [7:0] INPUT_LOOP_CTRL_OFS = 8'h1c;

  // Field positions inside the register.
  localparam int unsigned SIGNED_SEL_BIT = 7;
  localparam int unsigned GAIN_REDUCE_BIT = 6;
  localparam int unsigned SAMPLE_LSB = 4;
  localparam int unsigned BLANK_LSB = 2;
  localparam int unsigned DECAY_LSB = 0;
  localparam int unsigned CODE_W = 2;

  // Reset value: signed input on, gain reduce on, sample code 3, blank code 1, decay code 1.
  localparam logic [7:0] INPUT_LOOP_CTRL_RST = 8'hf5;

  // Amplitude path constants for an 8-bit input code.
  localparam int unsigned AMP_W = 8;
  localparam logic [7:0] AMP_MIDPOINT = 8'h80;
  localparam logic [7:0] AMP_FULL = 8'hff;

  // Clock period and the auto-resonance sampling periods, in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SAMPLE_TIME0_NS = 150000;
  localparam int unsigned SAMPLE_TIME1_NS = 200000;
  localparam int unsigned SAMPLE_TIME2_NS = 250000;
  localparam int unsigned SAMPLE_TIME3_NS = 300000;

  // Cycle counts derived from the times; these are longest periods, so they round down.
  localparam int unsigned SAMPLE_CYC0 = SAMPLE_TIME0_NS / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_CYC1 = SAMPLE_TIME1_NS / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_CYC2 = SAMPLE_TIME2_NS / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_CYC3 = SAMPLE_TIME3_NS / CLK_PERIOD_NS;

  // Width of the interval timers, wide enough for the longest sampling period.
  localparam int unsigned TIMER_W = 16;

endpackage

// ---- verilog/interval_timer.sv ----
// One-shot interval timer with a restartable load and a completion strobe.
`timescale 1ns/1ps
`default_nettype none

module interval_timer #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [WIDTH-1:0] load_val,
  output logic busy,
  output logic done
);

  // Remaining cycles of the running interval.
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  // High while an interval is being timed.
  logic busy_q;
  logic busy_d;

  // The strobe is combinational so a caller may restart in the same cycle, keeping periods exact.
  assign done = busy_q && (cnt_q == WIDTH'(1));
  assign busy = busy_q;

  // Next-state logic: a start always wins, so a restart at completion loses no cycle.
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (start) begin
      // A zero load would wrap and run the whole counter range, so it is treated as one cycle.
      cnt_d = (load_val == '0) ? WIDTH'(1) : load_val;
      busy_d = 1'b1;
    end else if (done) begin
      busy_d = 1'b0;
    end else if (busy_q) begin
      cnt_d = cnt_q - WIDTH'(1);
    end
  end

  // State registers, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

endmodule
`default_nettype wire

// ---- verilog/haptic_loop_control_register.sv ----
// Input and loop timing control register with the amplitude mapping and timing it steers.
`timescale 1ns/1ps
`default_nettype none

module haptic_loop_control_register #(
  parameter int unsigned SAMPLE_CYC [4] = '{haptic_ctrl_pkg::SAMPLE_CYC0,
    haptic_ctrl_pkg::SAMPLE_CYC1, haptic_ctrl_pkg::SAMPLE_CYC2, haptic_ctrl_pkg::SAMPLE_CYC3},
  parameter int unsigned BLANK_CYC [4] = '{10, 20, 40, 80},
  parameter int unsigned DECAY_CYC [4] = '{10, 20, 40, 80}
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [haptic_ctrl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [haptic_ctrl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [haptic_ctrl_pkg::DATA_W-1:0] reg_rdata,
  input wire logic loop_closed,
  input wire logic [haptic_ctrl_pkg::AMP_W-1:0] amp_in,
  input wire logic fb_brake_req,
  input wire logic brake_near_done,
  input wire logic drive_cycle_end,
  output logic [haptic_ctrl_pkg::AMP_W-1:0] drive_mag,
  output logic brake_apply,
  output logic gain_reduce,
  output logic sample_tick,
  output logic decay_active,
  output logic blank_active,
  output logic bemf_convert
);
  import haptic_ctrl_pkg::*;

  // Picks one of four cycle counts by a two-bit code, cut to the timer width.
  function automatic logic [TIMER_W-1:0] pick_cycles(input logic [CODE_W-1:0] code,
                                                      input int unsigned tbl [4]);
    pick_cycles = TIMER_W'(tbl[code]);
  endfunction

  // Doubles an amplitude difference to full scale, saturating at the top code.
  function automatic logic [AMP_W-1:0] scale_twice(input logic [AMP_W:0] diff);
    logic [AMP_W+1:0] dbl;
    dbl = {diff, 1'b0};
    scale_twice = (dbl > {2'b00, AMP_FULL}) ? AMP_FULL : dbl[AMP_W-1:0];
  endfunction

  // The stored register and its next value.
  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] ctrl_d;
  // Registered read data.
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  // Decoded register fields.
  logic signed_input_select;
  logic brake_gain_reduce;
  logic [CODE_W-1:0] sample_code;
  logic [CODE_W-1:0] blank_code;
  logic [CODE_W-1:0] current_decay_period;
  // Access hits on our offset.
  logic hit;

  assign hit = (reg_addr == INPUT_LOOP_CTRL_OFS);
  assign signed_input_select = ctrl_q[SIGNED_SEL_BIT];
  assign brake_gain_reduce = ctrl_q[GAIN_REDUCE_BIT];
  assign sample_code = ctrl_q[SAMPLE_LSB +: CODE_W];
  assign blank_code = ctrl_q[BLANK_LSB +: CODE_W];
  assign current_decay_period = ctrl_q[DECAY_LSB +: CODE_W];

  // Register file: a write stores every bit, a read returns the stored byte with no side effect.
  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    if (reg_wr && hit) begin
      ctrl_d = reg_wdata;
    end
    if (reg_rd) begin
      // Other offsets belong to neighbouring blocks, so this one answers zero there.
      rdata_d = hit ? ctrl_q : '0;
    end
  end

  // Register storage; signed input select comes up set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= INPUT_LOOP_CTRL_RST;
      rdata_q <= '0;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Amplitude mapping and braking decision, registered for the drive stage.
  logic [AMP_W-1:0] mag_q;
  logic [AMP_W-1:0] mag_d;
  logic brake_q;
  logic brake_d;
  logic gain_q;
  logic gain_d;

  // Next values of the drive stage outputs.
  always_comb begin
    mag_d = '0;
    brake_d = 1'b0;
    if (!signed_input_select) begin
      // Unsigned: the full code is magnitude, so no bit is spent on a sign.
      mag_d = amp_in;
      // Closed-loop use is assumed here; the host keeps open-loop out of this mode.
      brake_d = fb_brake_req;
    end else if (loop_closed) begin
      // Signed closed-loop: the lower half drives nothing, the top half scales up.
      if (amp_in > AMP_MIDPOINT) begin
        mag_d = scale_twice({1'b0, amp_in} - {1'b0, AMP_MIDPOINT});
      end
      brake_d = fb_brake_req;
    end else begin
      // Signed open-loop: below midpoint is reverse drive, which is braking.
      if (amp_in < AMP_MIDPOINT) begin
        mag_d = scale_twice({1'b0, AMP_MIDPOINT} - {1'b0, amp_in});
        brake_d = 1'b1;
      end else begin
        mag_d = scale_twice({1'b0, amp_in} - {1'b0, AMP_MIDPOINT});
      end
    end
    // Gain drops only while braking is live and almost done.
    gain_d = brake_gain_reduce && brake_d && brake_near_done;
  end

  // Drive stage registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mag_q <= '0;
      brake_q <= 1'b0;
      gain_q <= 1'b0;
    end else if (ce) begin
      mag_q <= mag_d;
      brake_q <= brake_d;
      gain_q <= gain_d;
    end
  end

  assign drive_mag = mag_q;
  assign brake_apply = brake_q;
  assign gain_reduce = gain_q;

  // Timers for sampling, current decay and blanking.
  logic samp_busy;
  logic samp_done;
  logic decay_busy;
  logic decay_done;
  logic blank_busy;
  logic blank_done;
  logic samp_start;

  // The sampling timer restarts on its own completion; a new code takes effect next period.
  assign samp_start = samp_done || !samp_busy;

  interval_timer #(.WIDTH(TIMER_W)) u_sample_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(samp_start),
    .load_val(pick_cycles(sample_code, SAMPLE_CYC)),
    .busy(samp_busy),
    .done(samp_done)
  );

  // Decay window opens at the end of each drive cycle.
  interval_timer #(.WIDTH(TIMER_W)) u_decay_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(drive_cycle_end),
    .load_val(pick_cycles(current_decay_period, DECAY_CYC)),
    .busy(decay_busy),
    .done(decay_done)
  );

  // Blanking follows the decay window, so the converter never sees flyback current.
  interval_timer #(.WIDTH(TIMER_W)) u_blank_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(decay_done),
    .load_val(pick_cycles(blank_code, BLANK_CYC)),
    .busy(blank_busy),
    .done(blank_done)
  );

  // Registered timing strobes and windows.
  logic tick_q;
  logic tick_d;
  logic conv_q;
  logic conv_d;
  logic decay_q;
  logic decay_d;
  logic blank_q;
  logic blank_d;

  // Next values of the timing outputs.
  always_comb begin
    tick_d = samp_done;
    conv_d = blank_done;
    decay_d = decay_busy && !decay_done;
    blank_d = blank_busy && !blank_done;
  end

  // Timing output registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
      conv_q <= 1'b0;
      decay_q <= 1'b0;
      blank_q <= 1'b0;
    end else if (ce) begin
      tick_q <= tick_d;
      conv_q <= conv_d;
      decay_q <= decay_d;
      blank_q <= blank_d;
    end
  end

  assign sample_tick = tick_q;
  assign bemf_convert = conv_q;
  assign decay_active = decay_q;
  assign blank_active = blank_q;

  // Checks on the register and the behaviour it steers.
  sequence s_write_hit;
    ce && reg_wr && hit;
  endsequence

  sequence s_decay_ends;
    ce && decay_done && !drive_cycle_end;
  endsequence

  chk_write_store: assert property (@(posedge clk) disable iff (!rst_n)
    s_write_hit |=> ctrl_q == $past(reg_wdata))
    else $error("register did not store written byte");

  chk_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    ce && reg_rd && hit && !reg_wr |=> reg_rdata == $past(ctrl_q) && ctrl_q == $past(ctrl_q))
    else $error("read did not return stored byte or disturbed it");

  chk_default_signed: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> signed_input_select && ctrl_q == INPUT_LOOP_CTRL_RST)
    else $error("reset value wrong");

  chk_unsigned_linear: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !signed_input_select |=> drive_mag == $past(amp_in) && brake_apply == $past(fb_brake_req))
    else $error("unsigned mapping or braking wrong");

  chk_open_brake: assert property (@(posedge clk) disable iff (!rst_n)
    ce && signed_input_select && !loop_closed |=> brake_apply == ($past(amp_in) < AMP_MIDPOINT))
    else $error("open-loop braking not tied to midpoint");

  chk_open_upper: assert property (@(posedge clk) disable iff (!rst_n)
    ce && signed_input_select && !loop_closed && amp_in >= AMP_MIDPOINT
    |=> drive_mag == AMP_W'(($past(amp_in) - AMP_MIDPOINT) << 1))
    else $error("open-loop positive half mapping wrong");

  chk_closed_dead: assert property (@(posedge clk) disable iff (!rst_n)
    ce && signed_input_select && loop_closed && amp_in <= AMP_MIDPOINT
    |=> drive_mag == '0 && brake_apply == $past(fb_brake_req))
    else $error("closed-loop lower half not silent");

  // The upper half doubles away from the midpoint; braking stays with the feedback.
  chk_closed_upper: assert property (@(posedge clk) disable iff (!rst_n)
    ce && signed_input_select && loop_closed && amp_in > AMP_MIDPOINT
    |=> drive_mag == AMP_W'(($past(amp_in) - AMP_MIDPOINT) << 1)
      && brake_apply == $past(fb_brake_req))
    else $error("closed-loop upper half mapping wrong");

  // The lower half is reverse drive; a zero code clips at the top of the scale.
  chk_open_lower: assert property (@(posedge clk) disable iff (!rst_n)
    ce && signed_input_select && !loop_closed && amp_in < AMP_MIDPOINT
    |=> drive_mag == (($past(amp_in) == '0) ? AMP_FULL
      : AMP_W'((AMP_MIDPOINT - $past(amp_in)) << 1)))
    else $error("open-loop negative half mapping wrong");

  // A low clock enable must hold the stored byte, the read answer and the drive level.
  chk_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> ctrl_q == $past(ctrl_q) && reg_rdata == $past(reg_rdata)
      && drive_mag == $past(drive_mag))
    else $error("state moved while clock enable was low");

  chk_gain_reduce: assert property (@(posedge clk) disable iff (!rst_n)
    ce && brake_gain_reduce && brake_near_done && fb_brake_req && (loop_closed || !signed_input_select)
    |=> gain_reduce)
    else $error("gain not reduced near brake end");

  chk_decay_then_blank: assert property (@(posedge clk) disable iff (!rst_n)
    s_decay_ends |=> blank_busy ##0 (ce ##1 blank_active))
    else $error("blanking did not follow decay");

endmodule
`default_nettype wire

// ---- test/host_model.sv ----
// Host model that reaches the control register and sets the loop mode line.
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input wire logic clk,
  output logic [haptic_ctrl_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic [haptic_ctrl_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_rd,
  input wire logic [haptic_ctrl_pkg::DATA_W-1:0] reg_rdata,
  output logic loop_closed
);
  import haptic_ctrl_pkg::*;

  // The bus starts idle with no strobe raised.
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    loop_closed = 1'b1;
  end

  // One write, held across exactly one rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  // One read; the answer is registered, so it is taken after the accepting edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  // Unsigned input is only ever chosen with the loop closed.
  task automatic cfg(input logic [7:0] d, input logic closed);
    wr(INPUT_LOOP_CTRL_OFS, d);
    loop_closed = d[SIGNED_SEL_BIT] ? closed : 1'b1;
  endtask
endmodule

`default_nettype wire

// ---- test/haptic_loop_control_register_bench.sv ----
// Self-checking bench for the input and loop timing control register.
`timescale 1ns/1ps
`default_nettype none

module haptic_loop_control_register_bench;
  import haptic_ctrl_pkg::*;

  // Short sampling periods keep the run brief; window lengths stay at defaults.
  localparam int unsigned S_CYC [4] = '{15, 20, 25, 30};
  localparam int unsigned W_CYC [4] = '{10, 20, 40, 80};

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  // Clock enable, lowered once to prove that a frozen block ignores a write.
  logic ce = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, drive_mag, rd_val;
  logic [7:0] amp_in = 8'h80;
  logic reg_wr, reg_rd, loop_closed, brake_apply, gain_reduce;
  logic sample_tick, decay_active, blank_active, bemf_convert;
  logic fb_brake_req = 1'b0;
  logic brake_near_done = 1'b0;
  logic drive_cycle_end = 1'b0;
  logic [7:0] amps [7] = '{8'h00, 8'h01, 8'h40, 8'h80, 8'h81, 8'hc0, 8'hff};
  logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};
  int miscompares = 0;
  int n_tests = 0;
  int n, d, b, v;

  always #5 clk = ~clk;

  haptic_loop_control_register #(.SAMPLE_CYC(S_CYC), .BLANK_CYC(W_CYC), .DECAY_CYC(W_CYC)) dut_u (
    .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_closed(loop_closed),
    .amp_in(amp_in), .fb_brake_req(fb_brake_req), .brake_near_done(brake_near_done),
    .drive_cycle_end(drive_cycle_end), .drive_mag(drive_mag), .brake_apply(brake_apply),
    .gain_reduce(gain_reduce), .sample_tick(sample_tick), .decay_active(decay_active),
    .blank_active(blank_active), .bemf_convert(bemf_convert));

  host_model host_u (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_closed(loop_closed));

  // Counts every comparison and reports a mismatch at once.
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  // The single place where the run ends.
  task automatic wrap_up();
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Expected {brake, magnitude}; the signed open case saturates at full negative scale.
  function automatic logic [8:0] exp_map(logic sgn, logic closed, logic [7:0] a, logic fb);
    int m;
    logic br;
    br = fb;
    m = a;
    if (sgn && closed && a <= 8'h80) begin
      m = 0;
    end else if (sgn && a < 8'h80) begin
      m = 2 * (128 - a);
      br = 1'b1;
    end else if (sgn) begin
      m = 2 * (a - 128);
      br = closed ? fb : 1'b0;
    end
    if (m > 255) begin
      m = 255;
    end
    return {br, m[7:0]};
  endfunction

  // Measures the gap between two sampling strobes; a lost strobe ends the run.
  task automatic tick_gap(output int g);
    int k;
    k = 0;
    g = 0;
    // A strobe already showing may start a period timed with the old code, so skip it.
    @(negedge clk);
    while (sample_tick !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    do begin
      @(negedge clk);
      g++;
    end while (sample_tick !== 1'b1 && g < 100);
    if (k == 100 || g == 100) begin
      miscompares++;
      wrap_up();
    end
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    host_u.rd(INPUT_LOOP_CTRL_OFS, rd_val);
    check("reset value", INPUT_LOOP_CTRL_RST, rd_val);
    // A write to the neighbour offset must not disturb our register.
    foreach (pats[i]) begin
      host_u.wr(INPUT_LOOP_CTRL_OFS, pats[i]);
      host_u.wr(8'h1d, ~pats[i]);
      host_u.rd(INPUT_LOOP_CTRL_OFS, rd_val);
      check("readback", pats[i], rd_val);
    end
    host_u.rd(8'h1d, rd_val);
    check("unmapped read", 8'h00, rd_val);
    // With the clock enable low a write must leave the register untouched.
    ce = 1'b0;
    host_u.wr(INPUT_LOOP_CTRL_OFS, 8'h3c);
    ce = 1'b1;
    host_u.rd(INPUT_LOOP_CTRL_OFS, rd_val);
    check("frozen write", pats[3], rd_val);
    // Modes: unsigned, signed closed-loop, signed open-loop.
    for (int m = 0; m < 3; m++) begin
      host_u.cfg((m == 0) ? 8'h75 : 8'hf5, m == 1);
      foreach (amps[i]) begin
        for (int f = 0; f < 2; f++) begin
          amp_in = amps[i];
          fb_brake_req = f[0];
          repeat (2) @(negedge clk);
          check("drive", exp_map(m != 0, m != 2, amps[i], f[0]), {brake_apply, drive_mag});
        end
      end
    end
    fb_brake_req = 1'b1;
    for (int g = 0; g < 4; g++) begin
      host_u.cfg({1'b1, g[1], 6'h35}, 1'b1);
      brake_near_done = g[0];
      repeat (2) @(negedge clk);
      check("gain reduce", g[1] & g[0], gain_reduce);
    end
    for (int c = 0; c < 4; c++) begin
      host_u.cfg({2'b11, c[1:0], 4'h5}, 1'b1);
      tick_gap(n);
      check("sample period", S_CYC[c], n);
    end
    // Both window codes move together, so one drive cycle end exercises both.
    for (int c = 0; c < 4; c++) begin
      host_u.cfg({4'hf, c[1:0], c[1:0]}, 1'b1);
      drive_cycle_end = 1'b1;
      @(negedge clk);
      drive_cycle_end = 1'b0;
      d = 0;
      b = 0;
      v = 0;
      repeat (200) begin
        @(negedge clk);
        d += (decay_active === 1'b1);
        b += (blank_active === 1'b1);
        v += (bemf_convert === 1'b1);
      end
      check("decay window", W_CYC[c] - 1, d);
      check("blank window", W_CYC[c] - 1, b);
      check("conversions", 1, v);
    end
    wrap_up();
  end
endmodule

`default_nettype wire
